// [scp_clock_ctrl.sv]
// System clock source selection, divider, PLL control and relock timing behind AHB-Lite
`timescale 1ns/1ns
`default_nettype none

module scp_clock_ctrl
  import scp_pkg::*;
#(
  parameter logic [12:0] RELOCK_COUNT = SCP_RELOCK_LOAD
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic main_oscillator_tick_in,
  input wire logic iosc_tick_in,
  input wire logic slow_osc_tick_in,
  input wire logic pll_tick_in,
  output logic sys_clk_tick_out,
  output logic adc_clk_tick_out,
  output logic pll_power_out,
  output logic [8:0] pll_mult_out,
  output logic pll_lock_out,
  output logic pll_in_use_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic pend_q;
  logic pend_wr_q;
  logic [11:0] pend_addr_q;
  logic [31:0] run_clock_config_q;
  logic [31:0] run_clock_config_ext_q;
  logic [8:0] crystal_pll_translation_q;
  logic pll_lock_raw_flag_q;
  logic [31:0] read_word;
  logic take_req;
  logic wr_commit;

  // One wait state: data phase ends on the second edge after the address phase
  assign take_req = hsel_in && hready_in && htrans_in[1];
  assign wr_commit = pend_q && pend_wr_q && hreadyout_out;

  always_comb begin
    read_word = 32'h0000_0000;
    case (pend_addr_q)
      SCP_RIS_ADDR: read_word[SCP_RIS_LOCK_BIT] = pll_lock_raw_flag_q;
      SCP_RCC_ADDR: read_word = run_clock_config_q;
      SCP_XLATE_ADDR: read_word[8:0] = crystal_pll_translation_q;
      SCP_RUN_CLOCK_CONFIG_EXT_ADDR: read_word = run_clock_config_ext_q;
      default: read_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pend_q <= 1'b0;
      pend_wr_q <= 1'b0;
      pend_addr_q <= 12'h000;
      hreadyout_out <= 1'b1;
      hrdata_out <= 32'h0000_0000;
    end else if (hreadyout_out) begin
      pend_q <= take_req;
      if (take_req) begin
        pend_wr_q <= hwrite_in;
        pend_addr_q <= (haddr_in[31:12] == 20'h00000) ? haddr_in[11:0] : 12'hFFF;
        hreadyout_out <= 1'b0;
      end
    end else begin
      hreadyout_out <= 1'b1;
      hrdata_out <= pend_wr_q ? 32'h0000_0000 : read_word;
    end
  end

  assign hresp_out = 1'b0;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      run_clock_config_q <= SCP_RCC_RESET;
      run_clock_config_ext_q <= SCP_RUN_CLOCK_CONFIG_EXT_RESET;
    end else if (wr_commit) begin
      if (pend_addr_q == SCP_RCC_ADDR) begin
        run_clock_config_q <= hwdata_in & SCP_RCC_WMASK;
      end
      if (pend_addr_q == SCP_RUN_CLOCK_CONFIG_EXT_ADDR) begin
        run_clock_config_ext_q <= hwdata_in & SCP_RUN_CLOCK_CONFIG_EXT_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Effective configuration

  logic use_ext_config;
  logic [3:0] crystal_select;
  logic [3:0] sys_divider_code;
  logic [5:0] sys_divider_code_ext;
  logic pll_bypass_ext;
  logic divider_use;
  logic eff_bypass;
  logic eff_pwrdn;
  logic [1:0] eff_osc;
  logic [5:0] eff_div_code;
  logic [5:0] div_limit;

  assign use_ext_config = run_clock_config_ext_q[SCP_RUN_CLOCK_CONFIG_EXT_USE_BIT];
  assign crystal_select = run_clock_config_q[SCP_RCC_CRYSTAL_SELECT_LSB +: 4];
  assign sys_divider_code = run_clock_config_q[SCP_RCC_DIV_LSB +: 4];
  assign sys_divider_code_ext = run_clock_config_ext_q[SCP_RUN_CLOCK_CONFIG_EXT_DIV_LSB +: 6];
  assign pll_bypass_ext = run_clock_config_ext_q[SCP_RUN_CLOCK_CONFIG_EXT_BYPASS_BIT];
  assign divider_use = run_clock_config_q[SCP_RCC_DIVUSE_BIT];

  always_comb begin
    if (use_ext_config) begin
      eff_bypass = pll_bypass_ext;
      eff_pwrdn = run_clock_config_ext_q[SCP_RUN_CLOCK_CONFIG_EXT_PWRDN_BIT];
      eff_osc = run_clock_config_ext_q[SCP_RUN_CLOCK_CONFIG_EXT_OSC_LSB +: 2];
      eff_div_code = sys_divider_code_ext;
    end else begin
      eff_bypass = run_clock_config_q[SCP_RCC_BYPASS_BIT];
      eff_pwrdn = run_clock_config_q[SCP_RCC_PWRDN_BIT];
      eff_osc = run_clock_config_q[SCP_RCC_OSC_LSB +: 2];
      eff_div_code = {2'b00, sys_divider_code};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PLL translation and relock timing

  scp_lock_t lock_q;
  logic [3:0] crystal_prev_q;
  logic pwrdn_prev_q;
  logic [12:0] relock_cnt_q;
  logic relock_start;
  logic relock_done;

  // Identical rewrites leave the crystal code unchanged and start nothing
  assign relock_start = !eff_pwrdn &&
                        ((crystal_select != crystal_prev_q) || pwrdn_prev_q);
  assign relock_done = (lock_q == SCP_LK_RELOCK) && main_oscillator_tick_in &&
                       (relock_cnt_q == 13'h0001);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      crystal_prev_q <= SCP_RCC_RESET[SCP_RCC_CRYSTAL_SELECT_LSB +: 4];
      pwrdn_prev_q <= 1'b1;
      crystal_pll_translation_q <= scp_xlate(SCP_RCC_RESET[SCP_RCC_CRYSTAL_SELECT_LSB +: 4]);
    end else begin
      crystal_prev_q <= crystal_select;
      pwrdn_prev_q <= eff_pwrdn;
      if (crystal_select != crystal_prev_q) begin
        crystal_pll_translation_q <= scp_xlate(crystal_select);
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      relock_cnt_q <= 13'h0000;
    end else if (relock_start) begin
      relock_cnt_q <= RELOCK_COUNT;
    end else if (lock_q == SCP_LK_RELOCK && main_oscillator_tick_in && relock_cnt_q != 13'h0000) begin
      relock_cnt_q <= relock_cnt_q - 13'h0001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lock_q <= SCP_LK_OFF;
    end else begin
      case (lock_q)
        SCP_LK_OFF: begin
          if (relock_start) begin
            lock_q <= SCP_LK_RELOCK;
          end
        end
        SCP_LK_RELOCK: begin
          if (eff_pwrdn) begin
            lock_q <= SCP_LK_OFF;
          end else if (relock_done && !relock_start) begin
            lock_q <= SCP_LK_LOCKED;
          end
        end
        SCP_LK_LOCKED: begin
          if (eff_pwrdn) begin
            lock_q <= SCP_LK_OFF;
          end else if (relock_start) begin
            lock_q <= SCP_LK_RELOCK;
          end
        end
        default: lock_q <= SCP_LK_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pll_lock_raw_flag_q <= 1'b0;
    end else if (relock_start || eff_pwrdn) begin
      pll_lock_raw_flag_q <= 1'b0;
    end else if (relock_done) begin
      pll_lock_raw_flag_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source selection and system divider

  logic pll_half_q;
  logic [1:0] iosc_div_q;
  logic pll_half_tick;
  logic iosc_div4_tick;
  logic osc_tick;
  logic use_pll;
  logic src_tick;
  logic [5:0] div_cnt_q;
  logic [4:0] adc_cnt_q;
  logic sys_tick_d;

  assign pll_half_tick = pll_tick_in && pll_half_q && !eff_pwrdn;
  assign iosc_div4_tick = iosc_tick_in && (iosc_div_q == 2'h3);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pll_half_q <= 1'b0;
      iosc_div_q <= 2'h0;
    end else begin
      if (pll_tick_in) begin
        pll_half_q <= !pll_half_q;
      end
      if (iosc_tick_in) begin
        iosc_div_q <= iosc_div_q + 2'h1;
      end
    end
  end

  always_comb begin
    case (eff_osc)
      SCP_OSC_MAIN: osc_tick = main_oscillator_tick_in;
      SCP_OSC_INT: osc_tick = iosc_tick_in;
      SCP_OSC_INT_DIV4: osc_tick = iosc_div4_tick;
      SCP_OSC_SLOW: osc_tick = slow_osc_tick_in;
      default: osc_tick = main_oscillator_tick_in;
    endcase
  end

  // The PLL only takes over once locked, whatever software asked for
  assign use_pll = !eff_bypass && !eff_pwrdn && (lock_q == SCP_LK_LOCKED);
  assign src_tick = use_pll ? pll_half_tick : osc_tick;

  // Reserved PLL codes fall back to the fastest legal divisor
  always_comb begin
    if (use_pll && eff_div_code < SCP_PLL_MIN_DIV_CODE) begin
      div_limit = SCP_PLL_MIN_DIV_CODE;
    end else begin
      div_limit = eff_div_code;
    end
  end

  // Next system tick, shared with the converter path so that both follow one stream
  always_comb begin
    if (!divider_use) begin
      sys_tick_d = src_tick;
    end else if (src_tick && div_cnt_q >= div_limit) begin
      sys_tick_d = 1'b1;
    end else begin
      sys_tick_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      div_cnt_q <= 6'h00;
      sys_clk_tick_out <= 1'b0;
    end else if (!divider_use) begin
      div_cnt_q <= 6'h00;
      sys_clk_tick_out <= src_tick;
    end else if (src_tick) begin
      if (div_cnt_q >= div_limit) begin
        div_cnt_q <= 6'h00;
        sys_clk_tick_out <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 6'h01;
        sys_clk_tick_out <= 1'b0;
      end
    end else begin
      sys_clk_tick_out <= 1'b0;
    end
  end

  // Converter clock: 16 MHz from the PLL, else the system clock tick, divided or not
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      adc_cnt_q <= 5'h00;
      adc_clk_tick_out <= 1'b0;
    end else if (use_pll) begin
      if (pll_tick_in) begin
        if (adc_cnt_q == SCP_ADC_PLL_DIV - 5'h01) begin
          adc_cnt_q <= 5'h00;
          adc_clk_tick_out <= 1'b1;
        end else begin
          adc_cnt_q <= adc_cnt_q + 5'h01;
          adc_clk_tick_out <= 1'b0;
        end
      end else begin
        adc_clk_tick_out <= 1'b0;
      end
    end else begin
      // Without the PLL the converter follows the system tick, divided or not
      adc_cnt_q <= 5'h00;
      adc_clk_tick_out <= sys_tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status outputs

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pll_power_out <= 1'b0;
      pll_mult_out <= scp_xlate(SCP_RCC_RESET[SCP_RCC_CRYSTAL_SELECT_LSB +: 4]);
      pll_lock_out <= 1'b0;
      pll_in_use_out <= 1'b0;
    end else begin
      pll_power_out <= !eff_pwrdn;
      pll_mult_out <= crystal_pll_translation_q;
      pll_lock_out <= pll_lock_raw_flag_q;
      pll_in_use_out <= use_pll;
    end
  end

endmodule

`default_nettype wire

// [scp_pkg.sv]
// Constants, register map and field layout of the system clock and PLL control block
package scp_pkg;

  // Register byte addresses
  localparam logic [11:0] SCP_RIS_ADDR = 12'h050;
  localparam logic [11:0] SCP_RCC_ADDR = 12'h060;
  localparam logic [11:0] SCP_XLATE_ADDR = 12'h064;
  localparam logic [11:0] SCP_RUN_CLOCK_CONFIG_EXT_ADDR = 12'h070;

  // Primary configuration fields
  localparam int SCP_RCC_OSC_LSB = 4;
  localparam int SCP_RCC_CRYSTAL_SELECT_LSB = 6;
  localparam int SCP_RCC_BYPASS_BIT = 11;
  localparam int SCP_RCC_PWRDN_BIT = 13;
  localparam int SCP_RCC_DIVUSE_BIT = 22;
  localparam int SCP_RCC_DIV_LSB = 23;
  localparam logic [31:0] SCP_RCC_RESET = 32'h0780_3AD1;
  localparam logic [31:0] SCP_RCC_WMASK = 32'h07C0_3BF1;

  // Extended configuration fields
  localparam int SCP_RUN_CLOCK_CONFIG_EXT_OSC_LSB = 4;
  localparam int SCP_RUN_CLOCK_CONFIG_EXT_BYPASS_BIT = 11;
  localparam int SCP_RUN_CLOCK_CONFIG_EXT_PWRDN_BIT = 13;
  localparam int SCP_RUN_CLOCK_CONFIG_EXT_DIV_LSB = 23;
  localparam int SCP_RUN_CLOCK_CONFIG_EXT_USE_BIT = 31;
  localparam logic [31:0] SCP_RUN_CLOCK_CONFIG_EXT_RESET = 32'h0780_2810;
  localparam logic [31:0] SCP_RUN_CLOCK_CONFIG_EXT_WMASK = 32'h9F80_2830;

  // Status field
  localparam int SCP_RIS_LOCK_BIT = 6;

  // Oscillator source codes
  localparam logic [1:0] SCP_OSC_MAIN = 2'h0;
  localparam logic [1:0] SCP_OSC_INT = 2'h1;
  localparam logic [1:0] SCP_OSC_INT_DIV4 = 2'h2;
  localparam logic [1:0] SCP_OSC_SLOW = 2'h3;

  // Frequencies and counts
  localparam int SCP_PLL_VCO_KHZ = 400000;
  localparam int SCP_ADC_KHZ = 16000;
  localparam logic [4:0] SCP_ADC_PLL_DIV = 5'(SCP_PLL_VCO_KHZ / SCP_ADC_KHZ);
  localparam logic [5:0] SCP_PLL_MIN_DIV_CODE = 6'h03;
  localparam logic [12:0] SCP_RELOCK_LOAD = 13'h1200;

  // Crystal frequency for each crystal code, in kHz
  localparam logic [13:0] SCP_CRYSTAL_SELECT_KHZ [16] = '{
    14'd1000, 14'd1843, 14'd2000, 14'd2457, 14'd3579, 14'd3686, 14'd4000, 14'd4096,
    14'd4915, 14'd5000, 14'd5120, 14'd6000, 14'd6144, 14'd7373, 14'd8000, 14'd8192};

  // Lock tracking states, Gray coded along off, relock, locked
  typedef enum logic [1:0] {
    SCP_LK_OFF = 2'b00,
    SCP_LK_RELOCK = 2'b01,
    SCP_LK_LOCKED = 2'b11
  } scp_lock_t;

  // Feedback multiplier that brings the crystal nearest to the VCO target
  function automatic logic [8:0] scp_xlate(input logic [3:0] code);
    int khz;
    khz = int'(SCP_CRYSTAL_SELECT_KHZ[code]);
    return 9'((SCP_PLL_VCO_KHZ + khz / 2) / khz);
  endfunction

endpackage

// [scp_clock_ctrl_assertions.sv]
// Port-level property checker for the clock control block
`timescale 1ns/1ns
`default_nettype none
module scp_clock_ctrl_assertions
  import scp_pkg::*;
#(
  parameter logic [12:0] RELOCK_COUNT = SCP_RELOCK_LOAD
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic main_oscillator_tick_in,
  input wire logic iosc_tick_in,
  input wire logic slow_osc_tick_in,
  input wire logic pll_tick_in,
  input wire logic sys_clk_tick_out,
  input wire logic adc_clk_tick_out,
  input wire logic pll_power_out,
  input wire logic pll_lock_out,
  input wire logic pll_in_use_out
);
  logic any_tick;
  int relock_q;
  int relock_d;
  ////////////////////////////////////////////////////////////////////////////////
  // Any source tick, and main oscillator ticks seen while powered and not yet locked
  assign any_tick = main_oscillator_tick_in | iosc_tick_in | slow_osc_tick_in | pll_tick_in;
  assign relock_d = (!pll_power_out || pll_lock_out) ? 0 : relock_q + int'(main_oscillator_tick_in);
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      relock_q <= 0;
    end else begin
      relock_q <= relock_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  ready_pulse_a: assert property (hsel_in && hready_in && htrans_in[1] && hreadyout_out
    |=> !hreadyout_out ##1 hreadyout_out) else $error("wait state is not one cycle");
  pd_unused_a: assert property (!pll_power_out [*2] |-> !pll_in_use_out)
    else $error("PLL in use while powered down");
  pd_unlock_a: assert property (!pll_power_out [*2] |-> !pll_lock_out)
    else $error("lock shown while powered down");
  relock_len_a: assert property ($rose(pll_lock_out) |->
    relock_q >= int'(RELOCK_COUNT) - 1 && relock_q <= int'(RELOCK_COUNT) + 1)
    else $error("relock period has wrong length");
  tick_lock_a: assert property ($rose(pll_lock_out) |-> $past(main_oscillator_tick_in, 2))
    else $error("lock set without an oscillator tick");
  sys_src_a: assert property (sys_clk_tick_out |-> $past(any_tick))
    else $error("system tick without a source tick");
  adc_sys_a: assert property (!pll_power_out [*2] |-> adc_clk_tick_out == sys_clk_tick_out)
    else $error("converter tick differs from system tick");
  use_lock_a: assert property ($rose(pll_in_use_out) |-> ##[0:2] pll_lock_out)
    else $error("PLL taken into use before lock");
  cover property ($rose(pll_lock_out));
  cover property ($rose(pll_in_use_out));
  cover property (sys_clk_tick_out && pll_in_use_out);
endmodule
bind scp_clock_ctrl scp_clock_ctrl_assertions #(.RELOCK_COUNT(RELOCK_COUNT))
  scp_clock_ctrl_assertions_i (.mclk_in, .rst_in, .hsel_in, .htrans_in, .hready_in,
  .hreadyout_out, .main_oscillator_tick_in, .iosc_tick_in, .slow_osc_tick_in, .pll_tick_in,
  .sys_clk_tick_out, .adc_clk_tick_out, .pll_power_out, .pll_lock_out, .pll_in_use_out);
`default_nettype wire

// [scp_clock_ctrl_test.sv]
// Self-checking bench for the clock control block
`timescale 1ns/1ns
`default_nettype none
module scp_clock_ctrl_test;
  import scp_pkg::*;
  localparam int W = 1920;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, main_oscillator = 1'b0, iosc = 1'b0, slow = 1'b0, pll = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hready, hresp, sys, adc, pwr, lock, inuse;
  logic [8:0] mult;
  logic [15:0] lfsr = 16'h0048;
  int cyc = 0, n_errors = 0, check_count = 0;
  always #4 mclk_in = ~mclk_in;
  scp_clock_ctrl #(.RELOCK_COUNT(13'h0004)) scp_clock_ctrl_i (.mclk_in(mclk_in),
    .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .main_oscillator_tick_in(main_oscillator), .iosc_tick_in(iosc), .slow_osc_tick_in(slow), .pll_tick_in(pll),
    .sys_clk_tick_out(sys), .adc_clk_tick_out(adc), .pll_power_out(pwr),
    .pll_mult_out(mult), .pll_lock_out(lock), .pll_in_use_out(inuse));
  // Source ticks: main every 2, internal every 3, slow every 5, PLL every cycle
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    main_oscillator <= (cyc % 2 == 0);
    iosc <= (cyc % 3 == 0);
    slow <= (cyc % 5 == 0);
    pll <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] mul(input int c);
    int k;
    k = int'(SCP_CRYSTAL_SELECT_KHZ[c]);
    return 32'((SCP_PLL_VCO_KHZ + k / 2) / k);
  endfunction
  function automatic logic [31:0] run_clock_config(input int o, x, b, p, u, v);
    return 32'(o << 4 | x << 6 | b << 11 | p << 13 | u << 22 | v << 23);
  endfunction
  task automatic fail(input string m);
    n_errors++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail($sformatf("got %h expected %h", g, e));
    end
  endtask
  task automatic chk_rate(input int g, input int e);
    check_count++;
    if (g < e - 1 || g > e + 1) begin
      fail($sformatf("tick count %0d expected %0d", g, e));
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do begin
      @(posedge mclk_in);
      n++;
    end while (hready !== 1'b1 && n < 40);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge mclk_in);
      n++;
    end while (hready !== 1'b1 && n < 40);
    r = hrdata;
    if (n >= 40) begin
      fail("bus transfer hung");
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic meas(input logic [11:0] a, input logic [31:0] c, input int es, input int ea);
    int s, t;
    s = 0;
    t = 0;
    wr(a, c);
    repeat (300) @(posedge mclk_in);
    repeat (W) begin
      @(posedge mclk_in);
      s += int'(sys === 1'b1);
      t += int'(adc === 1'b1);
    end
    chk_rate(s, es);
    chk_rate(t, ea);
  endtask
  task automatic close_out();
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    int d;
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    chk(32'({pwr, lock, inuse, hresp}), 32'h0);
    rd(SCP_RCC_ADDR, SCP_RCC_RESET);
    rd(SCP_RUN_CLOCK_CONFIG_EXT_ADDR, SCP_RUN_CLOCK_CONFIG_EXT_RESET);
    rd(SCP_RIS_ADDR, 32'h0);
    rd(SCP_XLATE_ADDR, mul(11));
    rd(12'h100, 32'h0);
    wr(SCP_RIS_ADDR, '1);
    wr(SCP_XLATE_ADDR, '1);
    rd(SCP_XLATE_ADDR, mul(11));
    wr(SCP_RUN_CLOCK_CONFIG_EXT_ADDR, '1);
    rd(SCP_RUN_CLOCK_CONFIG_EXT_ADDR, SCP_RUN_CLOCK_CONFIG_EXT_WMASK);
    wr(SCP_RUN_CLOCK_CONFIG_EXT_ADDR, 32'h0);
    meas(SCP_RCC_ADDR, SCP_RCC_RESET, W / 3, W / 3);
    for (int o = 0; o < 4; o++) begin
      d = (o == 0) ? 2 : (o == 1) ? 3 : (o == 2) ? 12 : 5;
      meas(SCP_RCC_ADDR, run_clock_config(o, 11, 1, 1, 0, 15), W / d, W / d);
    end
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      d = (i == 0) ? 0 : (i == 1) ? 15 : int'(lfsr[3:0]);
      meas(SCP_RCC_ADDR, run_clock_config(0, 11, 1, 1, 1, d), W / 2 / (d + 1), W / 2 / (d + 1));
    end
    for (int c = 0; c < 16; c++) begin
      wr(SCP_RCC_ADDR, run_clock_config(0, c, 1, 1, 0, 15));
      rd(SCP_XLATE_ADDR, mul(c));
      chk(32'(mult), mul(c));
    end
    // Main oscillator runs and the crystal is in the PLL range before the PLL is chosen
    wr(SCP_RCC_ADDR, run_clock_config(0, 11, 0, 0, 1, 3));
    chk(32'(inuse), 32'h0);
    rd(SCP_RIS_ADDR, 32'h0);
    d = 0;
    do begin
      bus(1'b0, SCP_RIS_ADDR, 32'h0, r);
      d++;
    end while (r[SCP_RIS_LOCK_BIT] !== 1'b1 && d < 50);
    chk(r, 32'h40);
    repeat (3) @(posedge mclk_in);
    chk(32'({lock, inuse}), 32'h3);
    meas(SCP_RCC_ADDR, run_clock_config(0, 11, 0, 0, 1, 3), W / 8, W / 25);
    meas(SCP_RCC_ADDR, run_clock_config(0, 11, 0, 0, 1, 1), W / 8, W / 25);
    rd(SCP_RIS_ADDR, 32'h40);
    wr(SCP_RCC_ADDR, run_clock_config(0, 14, 0, 0, 1, 1));
    rd(SCP_RIS_ADDR, 32'h0);
    chk(32'(mult), mul(14));
    meas(SCP_RUN_CLOCK_CONFIG_EXT_ADDR, run_clock_config(0, 0, 1, 0, 0, 63) | 32'h8000_0000, 15, 15);
    meas(SCP_RUN_CLOCK_CONFIG_EXT_ADDR, run_clock_config(0, 0, 0, 0, 0, 9) | 32'h8000_0000, 96, W / 25);
    close_out();
  end
  initial begin
    repeat (60000) @(posedge mclk_in);
    fail("watchdog expired");
    close_out();
  end
endmodule
`default_nettype wire
